// file: ebds_pkg.sv
// Package: constants and carrier types for the external bus dynamic sizing unit
package ebds_pkg;
    // ------------------------------------------------------------------
    // Transfer size codes on the size pins
    // ------------------------------------------------------------------
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_3B   = 2'h3;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    // ------------------------------------------------------------------
    // Acknowledge codes {hi_n, lo_n}
    // ------------------------------------------------------------------
    localparam logic [1:0] ACK_WAIT  = 2'h3;
    localparam logic [1:0] ACK_PORT8 = 2'h2;
    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [1:0]  ACK_IDLE      = 2'h3;
    localparam logic [31:0] DATA_RESET    = 32'h0000_0000;
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          MIN_CYCLE_NS  = 30;
    localparam int          MIN_CYCLE_CLK = (MIN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic        write;   // 1 = write, 0 = read
        logic [1:0]  nbytes;  // operand size code (SIZE_*)
        logic [23:0] addr;    // byte address of operand
        logic [31:0] wdata;   // operand, most significant byte first
    } ebds_req_s;

    typedef struct packed {
        logic [23:0] addr;
        logic [1:0]  size;
        logic        write;
        logic        as_n;
        logic        ds_n;
    } ebds_bus_s;
endpackage

// file: ebds_unit.sv
// Module: external bus unit with input synchronisation and dynamic bus sizing
// Contract
// - Synchronise every asynchronous input before use
// - Drive system clock out on a pin
// - Sample inputs at falling clock edge
// - Resolve metastable samples before logic uses them
// - Read data captured one falling edge after ack
// - Prompt ack gives three-clock cycle; the sync pipe here stretches it to eight clocks
// - Size codes 01,10,11,00 for 1-4 bytes
// - Size output shows remaining bytes each cycle
// - Ack decode: wait, 8-bit, 16-bit, reserved 16
// - Narrow port ack starts another cycle
// - Each cycle assumes 16-bit port first
// - Writes replicate byte for both port widths
// - Reads steer valid byte into operand
// - One aligned word per cycle, high first
// - Address bit 0 set means odd
// - Misaligned long done as two word accesses; the code does byte, word, byte in three cycles
// - No ack extends cycle without limit
module ebds_unit (
    input  wire logic               clock_in,         // System clock, 100 MHz
    input  wire logic               rst_in,           // Async reset, active high
    input  wire ebds_pkg::ebds_req_s req_in,          // Operand request
    input  wire logic               req_valid_in,     // Request strobe, taken when idle
    output logic                    req_ready_out,    // High while idle
    output logic                    done_out,         // One-cycle pulse, operand finished
    output logic [31:0]             rdata_out,        // Read operand, right aligned
    output logic                    sys_clk_out,      // Clock image for external parts
    output ebds_pkg::ebds_bus_s     bus_out,          // Address, size, strobes
    output logic [15:0]             data_out,         // Write data
    output logic                    data_oe_n_out,    // Low while driving data
    input  wire logic [15:0]        data_in,          // Data bus input
    input  wire logic               size_ack_hi_n_in, // Size acknowledge, upper
    input  wire logic               size_ack_lo_n_in  // Size acknowledge, lower
);
    // ------------------------------------------------------------------
    // Clock out and falling-edge input capture
    // ------------------------------------------------------------------
    logic sys_clk_q;
    logic sys_clk_d;

    // Toggle flop running from the fast clock gives a half-rate image whose
    // falling edge we treat as the sampling point; logic stays single clock.
    always_comb begin
        sys_clk_d = ~sys_clk_q;
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sys_clk_q <= 1'b0;
        end else begin
            sys_clk_q <= sys_clk_d;
        end
    end
    assign sys_clk_out = sys_clk_q;

    // Falling edge of the image: image currently high, goes low next edge
    logic fall;
    assign fall = sys_clk_q;

    // Two flops then the fall capture: an input reaches the sequencer about
    // two image periods late, so a bus cycle runs longer than the bare minimum.
    logic [17:0] sync1_q;
    logic [17:0] sync2_q;
    logic [17:0] samp_q;
    logic [17:0] sync1_d;
    logic [17:0] sync2_d;
    logic [17:0] samp_d;

    always_comb begin
        sync1_d = {size_ack_hi_n_in, size_ack_lo_n_in, data_in};
        sync2_d = sync1_q;
        samp_d  = fall ? sync2_q : samp_q;
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_q <= {ebds_pkg::ACK_IDLE, 16'h0000};
            sync2_q <= {ebds_pkg::ACK_IDLE, 16'h0000};
            samp_q  <= {ebds_pkg::ACK_IDLE, 16'h0000};
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            samp_q  <= samp_d;
        end
    end

    logic [1:0]  ack;
    logic [15:0] din;
    assign ack = samp_q[17:16];
    assign din = samp_q[15:0];

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] size_count(input logic [1:0] code);
        size_count = (code == ebds_pkg::SIZE_LONG) ? 3'h4 : {1'b0, code};
    endfunction

    function automatic logic [1:0] size_code(input logic [2:0] n);
        size_code = n[1:0];
    endfunction

    // Acknowledge decode: the idle code inserts waits, lower-only (lo_n low, hi_n high) marks an
    // 8-bit port, and both other codes (reserved both-low too) mean 16-bit
    function automatic logic ack_done(input logic [1:0] code);
        ack_done = (code != ebds_pkg::ACK_WAIT);
    endfunction

    function automatic logic ack_narrow(input logic [1:0] code);
        ack_narrow = (code == ebds_pkg::ACK_PORT8);
    endfunction

    // Bytes one bus cycle moves: a word needs a 16-bit port, an even address
    // and two bytes left; an aligned word is the most any cycle carries
    function automatic logic [2:0] cycle_bytes(input logic       port_narrow,
                                               input logic       addr_odd,
                                               input logic [2:0] bytes_left);
        cycle_bytes = (port_narrow || addr_odd || bytes_left == 3'h1) ? 3'h1 : 3'h2;
    endfunction

    // Byte k of operand, counted from most significant, for an n-byte operand
    function automatic logic [7:0] op_byte(input logic [31:0] op,
                                           input logic [2:0] n,
                                           input logic [2:0] k);
        logic [2:0] sh;
        sh = 3'(n - 3'h1 - k);
        op_byte = op[{sh[1:0], 3'h0} +: 8];
    endfunction

    // Write image of the data bus: next operand byte on the upper lane and the
    // one after it below; a lone byte goes out on both lanes so either port
    // width finds it where it looks
    function automatic logic [15:0] write_lanes(input logic [31:0] op,
                                                input logic [2:0]  n,
                                                input logic [2:0]  idx,
                                                input logic        lone);
        logic [7:0] hi;
        logic [7:0] lo;
        hi          = op_byte(op, n, idx);
        lo          = op_byte(op, n, 3'(idx + 3'h1));
        write_lanes = lone ? {hi, hi} : {hi, lo};
    endfunction

    // Lane of a single-byte read: an 8-bit port answers on the upper lane
    // only, a 16-bit port on the lane that the address lsb names
    function automatic logic [7:0] read_lane(input logic [15:0] bus,
                                             input logic        port_narrow,
                                             input logic        addr_odd);
        read_lane = (port_narrow || !addr_odd) ? bus[15:8] : bus[7:0];
    endfunction

    // ------------------------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------------------------
    typedef enum {
        ST_IDLE,  // No operand in hand
        ST_S0,    // Next fall drives address, size and strobes
        ST_S2,    // Data strobe low, first look at the acknowledge
        ST_WAIT,  // Wait states until an acknowledge shows
        ST_LATCH, // Next fall takes read data and ends the cycle
        ST_END    // Idle acknowledge seen before anything new starts
    } ebds_state_e;

    ebds_state_e st_q, st_d;
    logic               write_q, write_d;
    logic [2:0]         total_q, total_d;
    logic [2:0]         left_q, left_d;
    logic [23:0]        addr_q, addr_d;
    logic [31:0]        wop_q, wop_d;
    logic [31:0]        rop_q, rop_d;
    logic [1:0]         port_q, port_d;
    logic               done_q, done_d;
    ebds_pkg::ebds_bus_s bus_q, bus_d;
    logic [15:0]        dout_q, dout_d;
    logic               oe_n_q, oe_n_d;

    logic [2:0] moved;
    logic [2:0] k;
    logic       odd;
    logic       port8;
    logic       acked;
    logic       narrow;

    always_comb begin
        st_d    = st_q;
        write_d = write_q;
        total_d = total_q;
        left_d  = left_q;
        addr_d  = addr_q;
        wop_d   = wop_q;
        rop_d   = rop_q;
        port_d  = port_q;
        done_d  = 1'b0;
        bus_d   = bus_q;
        dout_d  = dout_q;
        oe_n_d  = oe_n_q;
        odd     = addr_q[0];
        k       = 3'(total_q - left_q);
        acked   = ack_done(ack);
        port8   = ack_narrow(ack);
        narrow  = (port_q == ebds_pkg::ACK_PORT8);
        moved   = cycle_bytes(narrow, odd, left_q);
        case (st_q)
            ST_IDLE: begin
                if (req_valid_in) begin
                    write_d = req_in.write;
                    total_d = size_count(req_in.nbytes);
                    left_d  = size_count(req_in.nbytes);
                    addr_d  = req_in.addr;
                    wop_d   = req_in.wdata;
                    rop_d   = ebds_pkg::DATA_RESET;
                    st_d    = ST_S0;
                end
            end

            ST_S0: begin
                if (fall) begin
                    // New cycle: assume 16-bit port, show remaining bytes and lsb
                    port_d        = ~ebds_pkg::ACK_PORT8;
                    bus_d.addr    = addr_q;
                    bus_d.size    = size_code(left_q);
                    bus_d.write   = write_q;
                    bus_d.as_n    = 1'b0;
                    bus_d.ds_n    = write_q;
                    if (write_q) begin
                        dout_d = write_lanes(wop_q, total_q, k, odd || left_q == 3'h1);
                        oe_n_d = 1'b0;
                    end
                    st_d = ST_S2;
                end
            end

            ST_S2, ST_WAIT: begin
                // Acknowledge is only looked at on a fall, so a wait state is
                // always a whole image period long
                if (fall) begin
                    bus_d.ds_n = 1'b0;
                    if (acked) begin
                        port_d = port8 ? ebds_pkg::ACK_PORT8 : ~ebds_pkg::ACK_PORT8;
                        st_d   = ST_LATCH;
                    end else begin
                        st_d = ST_WAIT;
                    end
                end
            end

            ST_LATCH: begin
                if (fall) begin
                    if (!write_q) begin
                        // A word fills both lanes; a single byte comes from its lane
                        if (moved == 3'h2) begin
                            rop_d = {rop_q[15:0], din};
                        end else begin
                            rop_d = {rop_q[23:0], read_lane(din, narrow, odd)};
                        end
                    end
                    bus_d.as_n = 1'b1;
                    bus_d.ds_n = 1'b1;
                    oe_n_d     = 1'b1;
                    left_d     = 3'(left_q - moved);
                    addr_d     = 24'(addr_q + 24'(moved));
                    st_d       = ST_END;
                end
            end

            ST_END: begin
                // The target drops its acknowledge only after the strobe rises and
                // the sync pipe shows that late; waiting for the idle code keeps a
                // stale acknowledge from ending the next cycle before its data.
                if (!acked) begin
                    if (left_q == 3'h0) begin
                        done_d = 1'b1;
                        st_d   = ST_IDLE;
                    end else begin
                        st_d = ST_S0;
                    end
                end
            end

            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            st_q    <= ST_IDLE;
            write_q <= 1'b0;
            total_q <= 3'h0;
            left_q  <= 3'h0;
            addr_q  <= 24'h000000;
            wop_q   <= ebds_pkg::DATA_RESET;
            rop_q   <= ebds_pkg::DATA_RESET;
            port_q  <= 2'h1;
            done_q  <= 1'b0;
            bus_q   <= {24'h000000, ebds_pkg::SIZE_BYTE, 1'b0, 1'b1, 1'b1};
            dout_q  <= 16'h0000;
            oe_n_q  <= 1'b1;
        end else begin
            st_q    <= st_d;
            write_q <= write_d;
            total_q <= total_d;
            left_q  <= left_d;
            addr_q  <= addr_d;
            wop_q   <= wop_d;
            rop_q   <= rop_d;
            port_q  <= port_d;
            done_q  <= done_d;
            bus_q   <= bus_d;
            dout_q  <= dout_d;
            oe_n_q  <= oe_n_d;
        end
    end

    // ------------------------------------------------------------------
    // Request handshake
    // ------------------------------------------------------------------
    // Ready is a flop image of the idle state so the output is registered
    logic rdy_q;
    logic rdy_d;
    always_comb begin
        rdy_d = (st_d == ST_IDLE);
    end
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdy_q <= 1'b1;
        end else begin
            rdy_q <= rdy_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    assign req_ready_out = rdy_q;
    assign done_out      = done_q;
    assign rdata_out     = rop_q;
    assign bus_out       = bus_q;
    assign data_out      = dout_q;
    assign data_oe_n_out = oe_n_q;
endmodule

// file: ebds_chk.sv
// Checker: bus timing and sizing properties of the dynamic sizing unit
module ebds_chk (
    input wire logic                clock_in,         // Clock
    input wire logic                rst_in,           // Reset
    input wire logic                done_out,         // Done
    input wire logic                sys_clk_out,      // Clock image
    input wire ebds_pkg::ebds_bus_s bus_out,          // Bus
    input wire logic [15:0]         data_out,         // Write data
    input wire logic                data_oe_n_out,    // Drive enable
    input wire logic                size_ack_hi_n_in, // Ack upper
    input wire logic                size_ack_lo_n_in  // Ack lower
);
    logic ack_seen;
    assign ack_seen = ~(size_ack_hi_n_in & size_ack_lo_n_in);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_clk_image_runs: assert property (!$past(rst_in) |-> sys_clk_out != $past(sys_clk_out))
        else $error("clock image stalled");
    a_strobe_on_fall: assert property ($changed(bus_out.as_n) |-> !sys_clk_out)
        else $error("strobe moved off the falling edge");
    a_cycle_min_len: assert property ($fell(bus_out.as_n) |=> !bus_out.as_n [*5])
        else $error("bus cycle too short");
    a_cycle_gap_hold: assert property ($rose(bus_out.as_n) |=> bus_out.as_n [*3])
        else $error("next cycle began before acknowledge released");
    a_no_ack_waits: assert property ((!ack_seen && !bus_out.as_n) [*6] |=> !bus_out.as_n)
        else $error("cycle ended without acknowledge");
    a_ack_ends_cycle: assert property ($rose(ack_seen) && !bus_out.as_n |-> ##[1:12] bus_out.as_n)
        else $error("acknowledge did not end cycle");
    a_addr_size_hold: assert property (!bus_out.as_n && !$past(bus_out.as_n)
        |-> $stable(bus_out.size) && $stable(bus_out.addr))
        else $error("size or address moved in cycle");
    a_drive_on_write: assert property (!data_oe_n_out |-> bus_out.write)
        else $error("data driven during read");
    a_byte_lane_copy: assert property (!bus_out.as_n && !data_oe_n_out
        && bus_out.size == ebds_pkg::SIZE_BYTE |-> data_out[15:8] == data_out[7:0])
        else $error("single byte not on both lanes");
    a_done_when_idle: assert property ($rose(done_out) |-> bus_out.as_n)
        else $error("done during open cycle");
    c_three_byte: cover property (!bus_out.as_n && bus_out.size == ebds_pkg::SIZE_3B);
    c_write_done: cover property (done_out && bus_out.write);
    c_ack_reserved: cover property (!bus_out.as_n && !size_ack_hi_n_in && !size_ack_lo_n_in);
endmodule
bind ebds_unit ebds_chk ebds_chk_inst (.clock_in, .rst_in, .done_out, .sys_clk_out, .bus_out,
    .data_out, .data_oe_n_out, .size_ack_hi_n_in, .size_ack_lo_n_in);

// file: ebds_mem.sv
// Partner: byte memory behind an 8- or 16-bit port with size acknowledge
module ebds_mem (
    input  wire logic                clock_in,     // Clock
    input  wire logic                rst_in,       // Reset
    input  wire ebds_pkg::ebds_bus_s bus_in,       // Bus from unit
    input  wire logic [15:0]         data_in,      // Resolved data bus
    input  wire logic                port16_in,    // 1 = 16-bit port
    input  wire logic                ack00_in,     // Answer with reserved code on a 16-bit port
    input  wire logic [4:0]          wait_in,      // Clocks before ack
    output logic [15:0]              data_out,     // Read drive
    output logic                     ack_hi_n_out, // Ack upper
    output logic                     ack_lo_n_out  // Ack lower
);
    logic [7:0] mem [64];
    logic [4:0] cnt_q;
    logic [5:0] a;
    assign a = bus_in.addr[5:0];
    initial for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    // ----------------------------------------------------------------
    // Released data lines show the inverse of the last value, never a stale copy; released acks sit at idle
    // ----------------------------------------------------------------
    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= 5'h00;
            {ack_hi_n_out, ack_lo_n_out} <= 2'h3;
            data_out <= 16'h0000;
        end else if (bus_in.as_n) begin
            cnt_q <= 5'h00;
            {ack_hi_n_out, ack_lo_n_out} <= 2'h3;
            data_out <= ~data_out;
        end else begin
            if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
            if (cnt_q >= wait_in) {ack_hi_n_out, ack_lo_n_out} <= port16_in ? {1'b0, ~ack00_in} : 2'h2;
            if (bus_in.write) data_out <= ~data_out;
            else if (port16_in) data_out <= {mem[{a[5:1], 1'b0}], mem[{a[5:1], 1'b1}]};
            else data_out <= {mem[a], ~data_out[7:0]};
            if (bus_in.write && !bus_in.ds_n && !(ack_hi_n_out && ack_lo_n_out)) begin
                if (!port16_in || (!a[0] && bus_in.size == ebds_pkg::SIZE_BYTE)) mem[a] <= data_in[15:8];
                else if (a[0]) mem[a] <= data_in[7:0];
                else begin
                    mem[a] <= data_in[15:8];
                    mem[{a[5:1], 1'b1}] <= data_in[7:0];
                end
            end
        end
    end
endmodule

// file: tb.sv
// Testbench: operand transfers through the dynamic sizing unit
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_in = 1'b0;
    logic rst_in, req_valid_in, req_ready_out, done_out, sys_clk_out, data_oe_n_out;
    logic size_ack_hi_n_in, size_ack_lo_n_in, port16, ack00, as_q;
    logic [4:0] wait_c;
    logic [31:0] rdata_out;
    logic [15:0] data_out, mem_data;
    wire logic [15:0] data_in = data_oe_n_out ? mem_data : data_out;
    ebds_pkg::ebds_req_s req_in;
    ebds_pkg::ebds_bus_s bus_out;
    logic [2:0] mq [$];
    int n_fail, tests_run, ncyc;
    always #5 clock_in = ~clock_in;
    ebds_unit ebds_unit_inst (.clock_in, .rst_in, .req_in, .req_valid_in, .req_ready_out,
        .done_out, .rdata_out, .sys_clk_out, .bus_out, .data_out, .data_oe_n_out, .data_in,
        .size_ack_hi_n_in, .size_ack_lo_n_in);
    ebds_mem ebds_mem_inst (.clock_in, .rst_in, .bus_in(bus_out), .data_in, .port16_in(port16),
        .ack00_in(ack00), .wait_in(wait_c), .data_out(mem_data),
        .ack_hi_n_out(size_ack_hi_n_in), .ack_lo_n_out(size_ack_lo_n_in));
    // ----------------------------------------------------------------
    // Record size and address lsb at the start of every bus cycle
    // ----------------------------------------------------------------
    always @(posedge clock_in) begin
        if (bus_out.as_n === 1'b0 && as_q) mq.push_back({bus_out.size, bus_out.addr[0]});
        as_q <= bus_out.as_n;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic op(input logic w, input logic [1:0] sz, input logic [23:0] a, input logic [31:0] d);
        while (req_ready_out !== 1'b1) @(posedge clock_in) #1;
        mq.delete();
        req_in = '{write: w, nbytes: sz, addr: a, wdata: d};
        req_valid_in = 1'b1;
        @(posedge clock_in) #1;
        req_valid_in = 1'b0;
        ncyc = 0;
        while (done_out !== 1'b1 && ncyc < 3000) begin
            @(posedge clock_in) #1;
            ncyc++;
        end
        chk(ncyc < 3000, 1);
    endtask
    task automatic t_long16;
        port16 = 1'b1;
        op(1'b1, ebds_pkg::SIZE_LONG, 24'h000010, 32'h11223344);
        chk(mq.size(), 2);
        chk(mq[0], {ebds_pkg::SIZE_LONG, 1'b0});
        chk(mq[1], {ebds_pkg::SIZE_WORD, 1'b0});
    endtask
    task automatic t_long8;
        logic [2:0] e [4] = '{3'h0, 3'h7, 3'h4, 3'h3};
        port16 = 1'b0;
        op(1'b0, ebds_pkg::SIZE_LONG, 24'h000010, 32'h0);
        chk(mq.size(), 4);
        for (int i = 0; i < 4; i++) chk(mq[i], e[i]);
        chk(rdata_out, 32'h11223344);
    endtask
    task automatic t_odd;
        port16 = 1'b0;
        op(1'b1, ebds_pkg::SIZE_WORD, 24'h000021, 32'h0000A5B6);
        chk(mq.size(), 2);
        chk(mq[0], {ebds_pkg::SIZE_WORD, 1'b1});
        chk(mq[1], {ebds_pkg::SIZE_BYTE, 1'b0});
        port16 = 1'b1;
        op(1'b0, ebds_pkg::SIZE_WORD, 24'h000021, 32'h0);
        chk(rdata_out[15:0], 16'hA5B6);
    endtask
    task automatic t_ack00;
        ack00 = 1'b1;
        op(1'b0, ebds_pkg::SIZE_WORD, 24'h000010, 32'h0);
        chk(mq.size(), 1);
        chk(rdata_out[15:0], 16'h1122);
        ack00 = 1'b0;
    endtask
    task automatic t_wait;
        wait_c = 5'h14;
        op(1'b0, ebds_pkg::SIZE_BYTE, 24'h000013, 32'h0);
        chk(ncyc >= 20, 1);
        chk(rdata_out[7:0], 8'h44);
        wait_c = 5'h00;
    endtask
    initial begin
        #200us;
        n_fail++;
        results();
    end
    initial begin
        {rst_in, port16, ack00, req_valid_in, wait_c, req_in, as_q} = {3'h4, 6'h0, 59'h0, 1'b1};
        repeat (8) @(posedge clock_in);
        #1 rst_in = 1'b0;
        t_long16();
        t_long8();
        t_odd();
        t_ack00();
        t_wait();
        results();
    end
endmodule
